//--- logic/tifos_cfg.svh
// Constants for the trigger input filter and output select block
`ifndef TIFOS_CFG_SVH
`define TIFOS_CFG_SVH

`define TIFOS_CLK_NS          50
`define TIFOS_US_NS           1000
`define TIFOS_CYC_PER_US      ((`TIFOS_US_NS + `TIFOS_CLK_NS - 1) / `TIFOS_CLK_NS)

`define TIFOS_OFS_CTRL        12'h000
`define TIFOS_OFS_FILTER      12'h004
`define TIFOS_OFS_COLOUR_PER  12'h008
`define TIFOS_OFS_STEREO_PER  12'h00C
`define TIFOS_OFS_STATUS      12'h010

`define TIFOS_CTRL_SYNC_SEL   0
`define TIFOS_CTRL_LEVEL      1
`define TIFOS_CTRL_MODE_LO    2
`define TIFOS_CTRL_MODE_HI    4
`define TIFOS_CTRL_PRIO       5

`define TIFOS_STAT_LEVEL      0
`define TIFOS_STAT_LOCKED     1
`define TIFOS_STAT_CNT_LO     16

`define TIFOS_RST_CTRL        32'h0000_0000
`define TIFOS_RST_FILTER      16'h000A
`define TIFOS_RST_PERIOD      16'h8235

`endif

//--- logic/tifos_filter.sv
// Glitch filter that qualifies the digital input pin
`timescale 1ns/1ps
module tifos_filter #(
  parameter int THR_W = 21
) (
  input  wire logic             pclk,     // Clock
  input  wire logic             presetn,  // Async reset, active low
  input  wire logic             pin_in,   // Raw digital input pin
  input  wire logic [THR_W-1:0] thr,      // Qualifying width in cycles
  output logic                  level,    // Synchronised input level
  output logic                  trig      // One-cycle qualified trigger
);
  import tifos_pkg::*;

  logic              meta_q;
  logic              sync_q;
  tifos_fstate_t     st_q;
  tifos_fstate_t     st_d;
  logic [THR_W-1:0]  cnt_q;
  logic [THR_W-1:0]  cnt_d;
  logic              trig_q;
  logic              trig_d;
  logic [THR_W-1:0]  thr_eff;

  assign thr_eff = (thr == '0) ? THR_W'(1) : thr;
  assign level   = sync_q;
  assign trig    = trig_q;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    trig_d = 1'b0;
    unique case (st_q)
      TIFOS_F_IDLE: begin
        if (sync_q) begin
          cnt_d = THR_W'(1);
          if (thr_eff == THR_W'(1)) begin
            trig_d = 1'b1;
            st_d   = TIFOS_F_HELD;
          end else begin
            st_d = TIFOS_F_COUNT;
          end
        end
      end
      TIFOS_F_COUNT: begin
        if (!sync_q) begin
          cnt_d = '0;
          st_d  = TIFOS_F_IDLE;
        end else begin
          cnt_d = cnt_q + THR_W'(1);
          if (cnt_d >= thr_eff) begin
            trig_d = 1'b1;
            st_d   = TIFOS_F_HELD;
          end
        end
      end
      TIFOS_F_HELD: begin
        if (!sync_q) begin
          cnt_d = '0;
          st_d  = TIFOS_F_IDLE;
        end
      end
      default: begin
        cnt_d = '0;
        st_d  = TIFOS_F_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      st_q   <= TIFOS_F_IDLE;
      cnt_q  <= '0;
      trig_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      trig_q <= trig_d;
    end
  end

  // Length of the current run of active input, for checking only
  logic [THR_W-1:0] run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
    end else if (!sync_q) begin
      run_q <= '0;
    end else if (run_q != '1) begin
      run_q <= run_q + THR_W'(1);
    end
  end

  a_trig_width: assert property (@(posedge pclk) disable iff (!presetn)
    trig_q |-> run_q == $past(thr_eff))
    else $error("trigger fired before input was active for the interval");

  a_trig_single: assert property (@(posedge pclk) disable iff (!presetn)
    trig_q |=> !trig_q)
    else $error("more than one trigger for one pulse");

  a_drop_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q != TIFOS_F_IDLE) && !sync_q |=> st_q == TIFOS_F_IDLE && cnt_q == '0)
    else $error("count not restarted after input dropped");

  a_narrow_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (run_q != '0) && (run_q < thr_eff) && !sync_q |=> !trig_q)
    else $error("trigger issued for a pulse narrower than the interval");

endmodule : tifos_filter

//--- logic/tifos_pkg.sv
// Types shared by the trigger input filter and output select block
package tifos_pkg;

  typedef enum logic [2:0] {
    TIFOS_MODE_DEFAULT  = 3'h0,
    TIFOS_MODE_LEADER   = 3'h1,
    TIFOS_MODE_FOLLOWER = 3'h2,
    TIFOS_MODE_LOCKED   = 3'h3,
    TIFOS_MODE_EVENT    = 3'h4,
    TIFOS_MODE_BURST    = 3'h5
  } tifos_mode_t;

  typedef enum logic [2:0] {
    TIFOS_F_IDLE  = 3'b001,
    TIFOS_F_COUNT = 3'b010,
    TIFOS_F_HELD  = 3'b100
  } tifos_fstate_t;

endpackage : tifos_pkg

//--- logic/tifos_top.sv
// Trigger input filter, output select and colour/stereo frame timing with APB registers
`timescale 1ns/1ps
`include "tifos_cfg.svh"
module tifos_top #(
  parameter int US_W  = 16,
  parameter int THR_W = 21
) (
  input  wire logic        pclk,           // Clock, 20 MHz
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic [31:0]      prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error on unmapped address
  input  wire logic        trig_pin,       // Digital input pin
  output logic             opto_out,       // Isolated output pin level
  output logic             colour_frame,   // Colour frame start pulse
  output logic             stereo_frame,   // Stereo frame start pulse
  output logic             event_trig,     // Qualified trigger in event modes
  output logic             frame_locked    // Colour/stereo lock in force
);
  import tifos_pkg::*;

  localparam int CYC = `TIFOS_CYC_PER_US;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction : hit

  logic [31:0]     ctrl_q, ctrl_d;
  logic [US_W-1:0] filt_q, filt_d;
  logic [US_W-1:0] cper_q, cper_d;
  logic [US_W-1:0] sper_q, sper_d;
  logic [31:0]     rdat_q, rdat_d;
  logic            err_q, err_d;
  logic [15:0]     tcnt_q, tcnt_d;

  logic            setup;
  logic            access;
  logic            mapped;
  tifos_mode_t     mode;
  logic            sync_sel;
  logic            man_level;
  logic            prio;

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign mapped    = hit(paddr, `TIFOS_OFS_CTRL) || hit(paddr, `TIFOS_OFS_FILTER) ||
                     hit(paddr, `TIFOS_OFS_COLOUR_PER) || hit(paddr, `TIFOS_OFS_STEREO_PER) ||
                     hit(paddr, `TIFOS_OFS_STATUS);
  assign mode      = tifos_mode_t'(ctrl_q[`TIFOS_CTRL_MODE_HI:`TIFOS_CTRL_MODE_LO]);
  assign sync_sel  = ctrl_q[`TIFOS_CTRL_SYNC_SEL];
  assign man_level = ctrl_q[`TIFOS_CTRL_LEVEL];
  assign prio      = ctrl_q[`TIFOS_CTRL_PRIO];
  assign pready    = 1'b1;
  assign prdata    = rdat_q;
  assign pslverr   = err_q;

  // Input filter
  logic             in_level;
  logic             trig;
  logic [THR_W-1:0] thr;

  assign thr = THR_W'(filt_q) * THR_W'(CYC);

  tifos_filter #(
    .THR_W (THR_W)
  ) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (trig_pin),
    .thr     (thr),
    .level   (in_level),
    .trig    (trig)
  );

  // Microsecond enable
  logic [4:0] div_q, div_d;
  logic       us_tick;
  assign us_tick = (div_q == 5'(CYC - 1));

  // Frame timers
  logic [US_W-1:0] ccnt_q, ccnt_d;
  logic [US_W-1:0] scnt_q, scnt_d;
  logic            cfr_q, cfr_d;
  logic            sfr_q, sfr_d;
  logic            opto_q, opto_d;
  logic            evt_q, evt_d;
  logic            lock_q, lock_d;
  logic            lock_now;
  logic            follow;

  assign lock_now = ((mode == TIFOS_MODE_DEFAULT) || (mode == TIFOS_MODE_EVENT)) &&
                    !prio &&
                    (cper_q == sper_q);
  assign follow   = (mode == TIFOS_MODE_FOLLOWER) || (mode == TIFOS_MODE_LOCKED);

  always_comb begin
    div_d  = us_tick ? 5'h00 : div_q + 5'h01;
    scnt_d = scnt_q;
    ccnt_d = ccnt_q;
    sfr_d  = 1'b0;
    cfr_d  = 1'b0;
    if (follow && trig) begin
      scnt_d = '0;
      sfr_d  = 1'b1;
    end else if (us_tick) begin
      if (scnt_q >= sper_q - US_W'(1)) begin
        scnt_d = '0;
        sfr_d  = 1'b1;
      end else begin
        scnt_d = scnt_q + US_W'(1);
      end
    end
    if (lock_now) begin
      ccnt_d = scnt_d;
      cfr_d  = sfr_d;
    end else if (us_tick) begin
      if (ccnt_q >= cper_q - US_W'(1)) begin
        ccnt_d = '0;
        cfr_d  = 1'b1;
      end else begin
        ccnt_d = ccnt_q + US_W'(1);
      end
    end
    opto_d = sync_sel ? sfr_d : man_level;
    evt_d  = trig && ((mode == TIFOS_MODE_EVENT) || (mode == TIFOS_MODE_BURST));
    lock_d = lock_now;
  end

  // Register file
  always_comb begin
    ctrl_d = ctrl_q;
    filt_d = filt_q;
    cper_d = cper_q;
    sper_d = sper_q;
    rdat_d = rdat_q;
    err_d  = 1'b0;
    tcnt_d = trig ? tcnt_q + 16'h0001 : tcnt_q;
    if (setup) begin
      err_d  = !mapped;
      rdat_d = 32'h0000_0000;
      if (!pwrite) begin
        if (hit(paddr, `TIFOS_OFS_CTRL)) begin
          rdat_d = ctrl_q;
        end else if (hit(paddr, `TIFOS_OFS_FILTER)) begin
          rdat_d = 32'(filt_q);
        end else if (hit(paddr, `TIFOS_OFS_COLOUR_PER)) begin
          rdat_d = 32'(cper_q);
        end else if (hit(paddr, `TIFOS_OFS_STEREO_PER)) begin
          rdat_d = 32'(sper_q);
        end else if (hit(paddr, `TIFOS_OFS_STATUS)) begin
          rdat_d[`TIFOS_STAT_LEVEL]                          = in_level;
          rdat_d[`TIFOS_STAT_LOCKED]                         = lock_q;
          rdat_d[`TIFOS_STAT_CNT_LO+15:`TIFOS_STAT_CNT_LO]   = tcnt_q;
        end
      end
    end else if (access) begin
      err_d = err_q;
    end
    if (access && pwrite) begin
      if (hit(paddr, `TIFOS_OFS_CTRL)) begin
        ctrl_d = {26'h0, pwdata[5:0]};
      end else if (hit(paddr, `TIFOS_OFS_FILTER)) begin
        filt_d = pwdata[US_W-1:0];
      end else if (hit(paddr, `TIFOS_OFS_COLOUR_PER)) begin
        cper_d = (pwdata[US_W-1:0] == '0) ? US_W'(1) : pwdata[US_W-1:0];
      end else if (hit(paddr, `TIFOS_OFS_STEREO_PER)) begin
        sper_d = (pwdata[US_W-1:0] == '0) ? US_W'(1) : pwdata[US_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TIFOS_RST_CTRL;
      filt_q <= `TIFOS_RST_FILTER;
      cper_q <= `TIFOS_RST_PERIOD;
      sper_q <= `TIFOS_RST_PERIOD;
      rdat_q <= 32'h0000_0000;
      err_q  <= 1'b0;
      tcnt_q <= 16'h0000;
      div_q  <= 5'h00;
      scnt_q <= '0;
      ccnt_q <= '0;
      sfr_q  <= 1'b0;
      cfr_q  <= 1'b0;
      opto_q <= 1'b0;
      evt_q  <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      filt_q <= filt_d;
      cper_q <= cper_d;
      sper_q <= sper_d;
      rdat_q <= rdat_d;
      err_q  <= err_d;
      tcnt_q <= tcnt_d;
      div_q  <= div_d;
      scnt_q <= scnt_d;
      ccnt_q <= ccnt_d;
      sfr_q  <= sfr_d;
      cfr_q  <= cfr_d;
      opto_q <= opto_d;
      evt_q  <= evt_d;
      lock_q <= lock_d;
    end
  end

  assign opto_out     = opto_q;
  assign colour_frame = cfr_q;
  assign stereo_frame = sfr_q;
  assign event_trig   = evt_q;
  assign frame_locked = lock_q;

  a_out_manual: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(sync_sel) |-> opto_out == $past(man_level))
    else $error("output pin does not follow manual level");

  a_out_sync: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sync_sel) |-> opto_out == stereo_frame)
    else $error("output pin does not follow frame sync");

  a_level_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    $past(sync_sel) && !stereo_frame |-> !opto_out)
    else $error("manual level leaked while sync select set");

  a_lock_offset: assert property (@(posedge pclk) disable iff (!presetn)
    frame_locked |-> colour_frame == stereo_frame)
    else $error("locked streams are not aligned");

  a_lock_cond: assert property (@(posedge pclk) disable iff (!presetn)
    frame_locked |-> !$past(prio) && $past(cper_q) == $past(sper_q))
    else $error("lock reported without its conditions");

  // Cycles since the last stereo frame; a register write restarts it
  logic [31:0] gap_q, gap_d;

  always_comb begin
    gap_d = gap_q + 32'h0000_0001;
    if (stereo_frame || (access && pwrite)) begin
      gap_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 32'h0000_0000;
    end else begin
      gap_q <= gap_d;
    end
  end

  a_streams_run: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == TIFOS_MODE_EVENT) || (mode == TIFOS_MODE_BURST)
      |-> gap_q < 32'(sper_q) * 32'(CYC))
    else $error("stereo stream stalled in event mode");

  a_event_fwd: assert property (@(posedge pclk) disable iff (!presetn)
    trig && (mode == TIFOS_MODE_EVENT) |=> event_trig)
    else $error("qualified trigger not forwarded in event mode");

  a_follow_frame: assert property (@(posedge pclk) disable iff (!presetn)
    trig && (mode == TIFOS_MODE_FOLLOWER) |=> stereo_frame)
    else $error("follower frame not started by trigger");

  sequence s_restart_trig;
    trig && ((mode == TIFOS_MODE_FOLLOWER) || (mode == TIFOS_MODE_LOCKED));
  endsequence

  a_restart_frame: assert property (@(posedge pclk) disable iff (!presetn)
    s_restart_trig |=> stereo_frame && (scnt_q == '0))
    else $error("stereo timer not restarted by trigger");

  a_follow_no_event: assert property (@(posedge pclk) disable iff (!presetn)
    trig && follow |=> !event_trig)
    else $error("event pulse issued in a follower mode");

  a_burst_fwd: assert property (@(posedge pclk) disable iff (!presetn)
    trig && (mode == TIFOS_MODE_BURST) |=> event_trig)
    else $error("qualified trigger not forwarded in burst mode");

  a_event_source: assert property (@(posedge pclk) disable iff (!presetn)
    event_trig |-> $past(trig))
    else $error("event pulse without a qualified trigger");

  a_idle_no_trig: assert property (@(posedge pclk) disable iff (!presetn)
    !in_level |=> !trig)
    else $error("trigger while synchronised input was low");

  a_trig_count: assert property (@(posedge pclk) disable iff (!presetn)
    trig |=> tcnt_q == $past(tcnt_q) + 16'h0001)
    else $error("qualified trigger not counted once");

  a_lock_mode: assert property (@(posedge pclk) disable iff (!presetn)
    frame_locked |-> ($past(mode) == TIFOS_MODE_DEFAULT) || ($past(mode) == TIFOS_MODE_EVENT))
    else $error("lock reported in a mode that cannot lock");

  a_prio_unlock: assert property (@(posedge pclk) disable iff (!presetn)
    $past(prio) |-> !frame_locked)
    else $error("lock reported with exposure priority set");

  a_colour_free: assert property (@(posedge pclk) disable iff (!presetn)
    !lock_now && us_tick && (ccnt_q >= cper_q - US_W'(1)) |=> colour_frame)
    else $error("free running colour frame missing");

endmodule : tifos_top

//--- testbench/test_trigger_input_filter_and_output_select.sv
// Testbench for the trigger filter and output select block
`timescale 1ns/1ps
module test_trigger_input_filter_and_output_select;
  logic        pclk, presetn, psel, penable, pwrite, fire;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, err_q, trig_pin;
  logic        opto_out, colour_frame, stereo_frame, event_trig, frame_locked;
  logic [15:0] width;
  int          err_count, tests_run, cyc, nc, ns, no, nb, d1, d2, n;

  tifos_top i_tifos_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pin(trig_pin), .opto_out(opto_out),
    .colour_frame(colour_frame), .stereo_frame(stereo_frame), .event_trig(event_trig),
    .frame_locked(frame_locked));
  tifos_trig_src i_tifos_trig_src (.pclk(pclk), .fire(fire), .width(width), .pin(trig_pin));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Counts frame, output and coincidence pulses over a window
  task automatic watch(input int cycles);
    nc = 0; ns = 0; no = 0; nb = 0;
    repeat (cycles) begin
      @(posedge pclk);
      nc += int'(colour_frame === 1'b1);
      ns += int'(stereo_frame === 1'b1);
      no += int'(opto_out === 1'b1);
      nb += int'(colour_frame === 1'b1 && stereo_frame === 1'b1);
    end
  endtask : watch

  // One pulse of w cycles; d is cycles to the first trigger, n the trigger count
  task automatic pulse(input logic [15:0] w, output int d);
    @(posedge pclk);
    fire <= 1'b1;
    width <= w;
    @(posedge pclk);
    fire <= 1'b0;
    n = 0;
    d = 0;
    ns = 0;
    for (int i = 1; i < 120; i++) begin
      @(posedge pclk);
      ns += int'(stereo_frame === 1'b1);
      if (event_trig === 1'b1) begin
        if (n == 0) d = i;
        n++;
      end
    end
  endtask : pulse

  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0); chk("ctrl", rd_q, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0); chk("filter", rd_q, 32'h0000_000A);
    apb(1'b0, 12'h008, 32'h0); chk("colour per", rd_q, 32'h0000_8235);
    apb(1'b0, 12'h00C, 32'h0); chk("stereo per", rd_q, 32'h0000_8235);
    apb(1'b0, 12'h020, 32'h0); chk("unmapped err", err_q, 32'h1);
  endtask : t_regs

  task automatic t_lock;
    apb(1'b1, 12'h008, 32'h3);
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h000, 32'h0);
    watch(150);
    watch(200);
    chk("locked", frame_locked, 1'b1);
    chk("rate match", nc, ns);
    chk("fixed offset", nb, nc);
    chk("frames run", nc > 0, 1'b1);
    apb(1'b1, 12'h000, 32'h20); watch(5);
    chk("prio lock", frame_locked, 1'b0);
    apb(1'b1, 12'h000, 32'h04); watch(5);
    chk("leader lock", frame_locked, 1'b0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h00C, 32'h4); watch(240);
    chk("rate lock", frame_locked, 1'b0);
    chk("colour free", nc, 4);
    chk("stereo free", ns, 3);
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h000, 32'h10); watch(200);
    chk("event lock", frame_locked, 1'b1);
    chk("event frames", ns > 0, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    chk("status lock", rd_q[1], 1'b1);
  endtask : t_lock

  task automatic t_out;
    apb(1'b1, 12'h000, 32'h02); watch(3);
    chk("opto high", opto_out, 1'b1);
    apb(1'b1, 12'h000, 32'h00); watch(3);
    chk("opto low", opto_out, 1'b0);
    apb(1'b1, 12'h000, 32'h12); watch(3);
    chk("opto event", opto_out, 1'b1);
    apb(1'b1, 12'h000, 32'h13); watch(3); watch(200);
    chk("opto sync", no, ns);
    chk("sync pulses", ns > 1, 1'b1);
  endtask : t_out

  task automatic t_filter;
    apb(1'b1, 12'h000, 32'h10);
    apb(1'b1, 12'h004, 32'h1);
    pulse(16'd10, d1); chk("glitch", n, 0);
    pulse(16'd15, d1); chk("glitch2", n, 0);
    pulse(16'd40, d1); chk("valid", n, 1);
    chk("min delay", d1 >= 20, 1'b1);
    apb(1'b1, 12'h004, 32'h2);
    pulse(16'd30, d2); chk("short", n, 0);
    pulse(16'd60, d2); chk("valid2", n, 1);
    chk("delay grows", d2 - d1, 20);
    apb(1'b0, 12'h010, 32'h0);
    chk("trig count", rd_q[31:16], 16'h0002);
  endtask : t_filter

  // Follower and locked modes restart the stereo frame; burst mode forwards the trigger
  task automatic t_follow;
    apb(1'b1, 12'h00C, 32'h100);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h000, 32'h08);
    pulse(16'd40, d2); chk("follow event", n, 0);
    chk("follow frame", ns, 1);
    apb(1'b1, 12'h000, 32'h0C);
    pulse(16'd40, d2); chk("locked frame", ns, 1);
    apb(1'b1, 12'h000, 32'h14);
    pulse(16'd40, d2); chk("burst event", n, 1);
    chk("burst delay", d2, d1);
    chk("burst frames", ns, 0);
  endtask : t_follow

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fire = 1'b0;
    width = 16'h0001;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_lock();
    t_out();
    t_filter();
    t_follow();
    complete_run();
  end
endmodule : test_trigger_input_filter_and_output_select

//--- testbench/tifos_trig_src.sv
// External trigger source model driving the digital input pin
`timescale 1ns/1ps
module tifos_trig_src (
  input  wire logic        pclk,   // Clock
  input  wire logic        fire,   // Start one pulse
  input  wire logic [15:0] width,  // Pulse width in cycles
  output logic             pin     // Driven trigger level
);
  logic [15:0] left_q;

  initial begin
    pin = 1'b0;
    left_q = 16'h0000;
  end

  // Pulse widths are chosen around the programmed interval by the bench
  always @(posedge pclk) begin
    if (fire) begin
      pin <= 1'b1;
      left_q <= width - 16'h0001;
    end else if (left_q != 16'h0000) begin
      left_q <= left_q - 16'h0001;
    end else begin
      pin <= 1'b0;
    end
  end
endmodule : tifos_trig_src
